// ### verilog/mgio_top.sv
// general-purpose port block: twelve bidirectional and three input ports
// assumes a register port with read data one cycle after the strobe,
// and watchdog, CE reset, clock stop and halt as same-clock levels
`timescale 1ns/1ps
`include "mgio_map.svh"
module mgio_top (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 watchdog_stack_reset_i,
    input  wire logic                 ce_reset_i,
    input  wire logic                 clock_stop_i,
    input  wire logic                 halt_i,
    input  wire mgio_pkg::mgio_addr_t addr_i,
    input  wire mgio_pkg::mgio_nib_t  wr_data_i,
    input  wire logic                 wr_en_i,
    input  wire logic                 rd_en_i,
    output mgio_pkg::mgio_nib_t       rd_data_o,
    input  wire logic [47:0]          bidir_pins_i,
    output logic      [47:0]          bidir_pins_o,
    output logic      [47:0]          bidir_oe_o,
    input  wire logic [11:0]          input_pins_i,
    output mgio_pkg::mgio_nib_t       pulldown_off_o
);
    localparam int NPORT = `MGIO_BIT_PORTS + `MGIO_GROUP_PORTS;

    logic [47:0]         bidir_lvl;
    logic [11:0]         in_lvl;
    logic [47:0]         views;
    logic                hold;
    logic                wr_ok;
    logic                rd_ok;
    mgio_pkg::mgio_nib_t rd_next;
    mgio_pkg::mgio_nib_t group_dir;

    assign hold  = halt_i | clock_stop_i | ce_reset_i;
    assign wr_ok = wr_en_i & ~hold & ~watchdog_stack_reset_i;
    assign rd_ok = rd_en_i & ~hold & ~watchdog_stack_reset_i;

    mgio_sync #(
        .W (48)
    ) u_sync_bidir (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   (bidir_pins_i),
        .level_o   (bidir_lvl)
    );

    mgio_sync #(
        .W (12)
    ) u_sync_in (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   (input_pins_i),
        .level_o   (in_lvl)
    );

    // port k at nibble k: 0..7 bitwise ports, 8..11 group ports
    genvar k;
    generate
        for (k = 0; k < NPORT; k++) begin : g_port
            logic                lat_we;
            logic                dir_we;
            logic                rmw;
            mgio_pkg::mgio_nib_t dir_wd;

            assign lat_we = wr_ok && (addr_i == 8'(`MGIO_PORT_BASE + k));
            assign rmw    = rd_ok && (k == 0)
                            && (addr_i == `MGIO_PORT_BASE);
            if (k < `MGIO_BIT_PORTS) begin : g_bitdir
                assign dir_we = wr_ok
                                && (addr_i == 8'(`MGIO_DIR_BASE + k));
                assign dir_wd = wr_data_i;
            end else begin : g_grpdir
                // one bit fans out to four pins
                assign dir_we = wr_ok && (addr_i == `MGIO_GROUP_DIR_ADDR);
                assign dir_wd = {4{wr_data_i[k - `MGIO_BIT_PORTS]}};
            end

            mgio_port #(
                .RMW_MASK ((k == 0) ? `MGIO_RMW_MASK_A0 : 4'h0)
            ) u_port (
                .clk_sys_i (clk_sys_i),
                .rst_n_i   (rst_n_i),
                .clear_i   (watchdog_stack_reset_i),
                .lat_we_i  (lat_we),
                .dir_we_i  (dir_we),
                .wd_i      (wr_data_i),
                .dir_wd_i  (dir_wd),
                .rmw_i     (rmw),
                .pin_i     (bidir_lvl[k*4 +: 4]),
                .view_o    (views[k*4 +: 4]),
                .lat_o     (bidir_pins_o[k*4 +: 4]),
                .dir_o     (bidir_oe_o[k*4 +: 4])
            );
        end
    endgenerate

    assign group_dir = {bidir_oe_o[44], bidir_oe_o[40],
                        bidir_oe_o[36], bidir_oe_o[32]};

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulldown_off_o <= `MGIO_NIB_RESET;
        end else if (watchdog_stack_reset_i) begin
            pulldown_off_o <= `MGIO_NIB_RESET;
        end else if (wr_ok && (addr_i == `MGIO_PULLDOWN_ADDR)) begin
            pulldown_off_o <= wr_data_i;
        end
    end

    // input-only ports read pins; writes decode to nothing
    always_comb begin
        rd_next = 4'h0;
        for (int p = 0; p < NPORT; p++) begin
            if (addr_i == 8'(`MGIO_PORT_BASE + p)) begin
                rd_next = views[p*4 +: 4];
            end
        end
        for (int d = 0; d < `MGIO_BIT_PORTS; d++) begin
            if (addr_i == 8'(`MGIO_DIR_BASE + d)) begin
                rd_next = bidir_oe_o[d*4 +: 4];
            end
        end
        if (addr_i == `MGIO_GROUP_DIR_ADDR) begin
            rd_next = group_dir;
        end
        if (addr_i == `MGIO_PULLDOWN_ADDR) begin
            rd_next = pulldown_off_o;
        end
        if (addr_i == `MGIO_IN_PD_ADDR) begin
            rd_next = in_lvl[3:0];
        end
        if (addr_i == `MGIO_IN_A1_ADDR) begin
            rd_next = in_lvl[7:4];
        end
        if (addr_i == `MGIO_IN_C1_ADDR) begin
            rd_next = in_lvl[11:8];
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 4'h0;
        end else if (rd_en_i) begin
            rd_data_o <= rd_next;
        end else begin
            rd_data_o <= 4'h0;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_bit_dir;
        wr_ok && addr_i == `MGIO_DIR_BASE |=>
            bidir_oe_o[3:0] == $past(wr_data_i);
    endproperty
    a_bit_dir: assert property (p_bit_dir)
        else $error("bitwise direction not taken");

    property p_group_dir;
        wr_ok && addr_i == `MGIO_GROUP_DIR_ADDR |=>
            bidir_oe_o[39:36] == {4{$past(wr_data_i[1])}};
    endproperty
    a_group_dir: assert property (p_group_dir)
        else $error("group direction not fanned out");

    property p_input_read;
        rd_en_i && addr_i == 8'h71 && bidir_oe_o[7:4] == 4'h0 |=>
            rd_data_o == $past(bidir_lvl[7:4]);
    endproperty
    a_input_read: assert property (p_input_read)
        else $error("input read not pin level");

    property p_input_write;
        wr_ok && addr_i == 8'h71 && bidir_oe_o[7:4] == 4'h0 |=>
            bidir_pins_o[7:4] == $past(wr_data_i)
            && bidir_oe_o[7:4] == 4'h0;
    endproperty
    a_input_write: assert property (p_input_write)
        else $error("latch not written in input mode");

    property p_output_write;
        wr_ok && addr_i == 8'h72 |=>
            bidir_pins_o[11:8] == $past(wr_data_i);
    endproperty
    a_output_write: assert property (p_output_write)
        else $error("written value not driven");

    property p_output_read;
        rd_en_i && addr_i == 8'h72 && bidir_oe_o[8] |=>
            rd_data_o[0] == $past(bidir_pins_o[8]);
    endproperty
    a_output_read: assert property (p_output_read)
        else $error("output read not latch");

    property p_rmw;
        rd_ok && addr_i == `MGIO_PORT_BASE && bidir_oe_o[3] |=>
            bidir_pins_o[3] == $past(bidir_lvl[3]);
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("upper pin latch not refreshed on read");

    property p_wdt_clear;
        watchdog_stack_reset_i |=>
            bidir_oe_o == 48'h0 && bidir_pins_o == 48'h0;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog reset left port state");

    property p_hold;
        hold && !watchdog_stack_reset_i |=>
            $stable(bidir_oe_o) && $stable(bidir_pins_o)
            && $stable(pulldown_off_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state changed while held");

    property p_pd_write;
        wr_ok && addr_i == `MGIO_PULLDOWN_ADDR |=>
            pulldown_off_o == $past(wr_data_i);
    endproperty
    a_pd_write: assert property (p_pd_write)
        else $error("pull-down select not written");

    property p_pd_wdt;
        watchdog_stack_reset_i |=> pulldown_off_o == 4'h0;
    endproperty
    a_pd_wdt: assert property (p_pd_wdt)
        else $error("pull-downs not reconnected");

    property p_latch_no_drive;
        wr_ok && addr_i == 8'h73 |=>
            $stable(bidir_oe_o[15:12]);
    endproperty
    a_latch_no_drive: assert property (p_latch_no_drive)
        else $error("latch write changed pin drive");

    property p_bit_dir_last;
        wr_ok && addr_i == 8'h5f |=>
            bidir_oe_o[31:28] == $past(wr_data_i);
    endproperty
    a_bit_dir_last: assert property (p_bit_dir_last)
        else $error("last bitwise direction not taken");

    property p_group_last;
        wr_ok && addr_i == `MGIO_GROUP_DIR_ADDR |=>
            bidir_oe_o[47:44] == {4{$past(wr_data_i[3])}};
    endproperty
    a_group_last: assert property (p_group_last)
        else $error("last group direction not fanned out");

    property p_dir_read;
        rd_en_i && addr_i == 8'h59 |=>
            rd_data_o == $past(bidir_oe_o[7:4]);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read back wrong");

    property p_group_read;
        rd_en_i && addr_i == 8'h78 && bidir_oe_o[32] |=>
            rd_data_o == $past(bidir_pins_o[35:32]);
    endproperty
    a_group_read: assert property (p_group_read)
        else $error("group output read not latch");

    property p_rmw_pin2;
        rd_ok && addr_i == `MGIO_PORT_BASE && bidir_oe_o[2] |=>
            bidir_pins_o[2] == $past(bidir_lvl[2]);
    endproperty
    a_rmw_pin2: assert property (p_rmw_pin2)
        else $error("pin 2 latch not refreshed on read");

    property p_rmw_low;
        rd_ok && addr_i == `MGIO_PORT_BASE |=>
            bidir_pins_o[1:0] == $past(bidir_pins_o[1:0]);
    endproperty
    a_rmw_low: assert property (p_rmw_low)
        else $error("lower latches touched by read");

    property p_quirk_read;
        rd_en_i && addr_i == `MGIO_PORT_BASE |=>
            rd_data_o[3:2] == $past(bidir_lvl[3:2]);
    endproperty
    a_quirk_read: assert property (p_quirk_read)
        else $error("upper pins of first port not read as pins");

    property p_retain;
        (ce_reset_i || clock_stop_i) && !watchdog_stack_reset_i |=>
            $stable(bidir_oe_o) && $stable(bidir_pins_o);
    endproperty
    a_retain: assert property (p_retain)
        else $error("state lost in CE reset or clock stop");

    property p_pd_retain;
        (ce_reset_i || clock_stop_i) && !watchdog_stack_reset_i |=>
            $stable(pulldown_off_o);
    endproperty
    a_pd_retain: assert property (p_pd_retain)
        else $error("pull-down select lost");

    property p_in_read;
        rd_en_i && addr_i == `MGIO_IN_A1_ADDR |=>
            rd_data_o == $past(in_lvl[7:4]);
    endproperty
    a_in_read: assert property (p_in_read)
        else $error("input port read not pin level");

    property p_in_write;
        wr_en_i && !watchdog_stack_reset_i && addr_i >= `MGIO_IN_PD_ADDR
            && addr_i <= `MGIO_IN_C1_ADDR |=>
            $stable(bidir_oe_o) && $stable(bidir_pins_o)
            && $stable(pulldown_off_o);
    endproperty
    a_in_write: assert property (p_in_write)
        else $error("input port write had an effect");

    property p_pd_read;
        rd_en_i && addr_i == `MGIO_PULLDOWN_ADDR |=>
            rd_data_o == $past(pulldown_off_o);
    endproperty
    a_pd_read: assert property (p_pd_read)
        else $error("pull-down select read back wrong");

    c_rmw: cover property (rd_ok && addr_i == `MGIO_PORT_BASE
                           && bidir_oe_o[3:2] != 2'b00);
    c_group: cover property (wr_ok && addr_i == `MGIO_GROUP_DIR_ADDR);
    c_wdt: cover property (watchdog_stack_reset_i && bidir_oe_o != 48'h0);
    c_pd: cover property (wr_ok && addr_i == `MGIO_PULLDOWN_ADDR);
endmodule : mgio_top

// ### verilog/mgio_map.svh
// address map, reset values and port counts of the general-purpose ports
// assumes an 8-bit data address inside the control bank
`ifndef MGIO_MAP_SVH
`define MGIO_MAP_SVH

`define MGIO_PULLDOWN_ADDR  8'h66
`define MGIO_GROUP_DIR_ADDR 8'h67
`define MGIO_DIR_BASE       8'h58
`define MGIO_PORT_BASE      8'h70
`define MGIO_IN_PD_ADDR     8'h7c
`define MGIO_IN_A1_ADDR     8'h7d
`define MGIO_IN_C1_ADDR     8'h7e
`define MGIO_NIB_RESET      4'h0
`define MGIO_RMW_MASK_A0    4'hc
`define MGIO_BIT_PORTS      8
`define MGIO_GROUP_PORTS    4

`endif

// ### verilog/mgio_pkg.sv
// shared types of the general-purpose port block
// assumes 4-bit data and 8-bit register addresses
package mgio_pkg;
    typedef logic [3:0] mgio_nib_t;
    typedef logic [7:0] mgio_addr_t;
endpackage : mgio_pkg

// ### verilog/mgio_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs asynchronous to clk_sys_i
`timescale 1ns/1ps
module mgio_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic level_reg;

            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_reg    <= 1'b0;
                    s2_reg    <= 1'b0;
                    s3_reg    <= 1'b0;
                    level_reg <= 1'b0;
                end else begin
                    s1_reg <= async_i[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // only a level seen twice counts; glitches stay out
                    if (s2_reg == s3_reg) begin
                        level_reg <= s3_reg;
                    end
                end
            end

            assign level_o[i] = level_reg;
        end
    endgenerate
endmodule : mgio_sync

// ### verilog/mgio_port.sv
// one 4-bit bidirectional port: output latch, direction, read view
// assumes synchronised pin levels and one-cycle write/read strobes
`timescale 1ns/1ps
`include "mgio_map.svh"
module mgio_port #(
    parameter mgio_pkg::mgio_nib_t RMW_MASK = 4'h0
) (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    input  wire logic                clear_i,
    input  wire logic                lat_we_i,
    input  wire logic                dir_we_i,
    input  wire mgio_pkg::mgio_nib_t wd_i,
    input  wire mgio_pkg::mgio_nib_t dir_wd_i,
    input  wire logic                rmw_i,
    input  wire mgio_pkg::mgio_nib_t pin_i,
    output mgio_pkg::mgio_nib_t      view_o,
    output mgio_pkg::mgio_nib_t      lat_o,
    output mgio_pkg::mgio_nib_t      dir_o
);
    mgio_pkg::mgio_nib_t rmw_bits;

    assign rmw_bits = RMW_MASK & dir_o;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_o <= `MGIO_NIB_RESET;
        end else if (clear_i) begin
            dir_o <= `MGIO_NIB_RESET;
        end else if (dir_we_i) begin
            dir_o <= dir_wd_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lat_o <= `MGIO_NIB_RESET;
        end else if (clear_i) begin
            lat_o <= `MGIO_NIB_RESET;
        end else if (lat_we_i) begin
            lat_o <= wd_i;
        end else if (rmw_i) begin
            // read copies pin level into latch bits set in both RMW_MASK and dir_o
            lat_o <= (lat_o & ~rmw_bits) | (pin_i & rmw_bits);
        end
    end

    // input pins and quirk pins show the pin
    assign view_o = (dir_o & ~RMW_MASK & lat_o) | (~(dir_o & ~RMW_MASK) & pin_i);
endmodule : mgio_port

// ### tb/mgio_board.sv
// board model: external drivers, floating pins and pull-downs
// assumes no pull on bidirectional pins; floating lines wander
`timescale 1ns/1ps
module mgio_board (
    input  wire logic        clk_sys_i,
    input  wire logic [47:0] out_i,
    input  wire logic [47:0] oe_i,
    input  wire logic [47:0] ext_i,
    input  wire logic [47:0] ext_drv_i,
    input  wire logic [11:0] in_ext_i,
    input  wire logic [11:0] in_drv_i,
    input  wire logic [3:0]  pd_off_i,
    output logic      [47:0] pin_o,
    output logic      [11:0] in_pin_o
);
    logic [47:0] last_reg;
    logic [11:0] in_last_reg;
    logic [11:0] pull;
    // undriven pin floats
    // board driver overpowers the port, like a shorted load
    assign pin_o = (ext_drv_i & ext_i) | (~ext_drv_i & oe_i & out_i)
                 | (~ext_drv_i & ~oe_i & ~last_reg);
    // resistor on while select bit is 0
    assign pull = {8'h00, ~pd_off_i};
    assign in_pin_o = (in_drv_i & in_ext_i)
                    | (~in_drv_i & ~pull & ~in_last_reg);
    always_ff @(posedge clk_sys_i) begin
        last_reg    <= pin_o;
        in_last_reg <= in_pin_o;
    end
endmodule : mgio_board

// ### tb/mgio_top_tb.sv
// self-checking bench of the general-purpose port block
// assumes reads answer one cycle after the strobe
`timescale 1ns/1ps
`include "mgio_map.svh"
module mgio_top_tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wdr = 1'b0, ce = 1'b0, cs = 1'b0, hlt = 1'b0;
    logic wr_en = 1'b0, rd_en = 1'b0, rd_seen = 1'b0;
    mgio_pkg::mgio_addr_t addr = 8'h00;
    mgio_pkg::mgio_nib_t  wdat = 4'h0, rd_data, pd_off, exp_n;
    mgio_pkg::mgio_nib_t  l, d, e, g;
    logic [47:0] pins_i, pins_o, oe, o_s, v_s;
    logic [47:0] ext = 48'h0, ext_drv = 48'h0;
    logic [11:0] in_ext = 12'h0, in_drv = 12'h0, in_pins;
    logic [31:0] seed = 32'hee47e949, r;
    mgio_pkg::mgio_nib_t exp_q[$];
    int n_fail = 0, n_checks = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    mgio_top u_mgio_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .watchdog_stack_reset_i(wdr), .ce_reset_i(ce),
        .clock_stop_i(cs), .halt_i(hlt), .addr_i(addr),
        .wr_data_i(wdat), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .rd_data_o(rd_data), .bidir_pins_i(pins_i),
        .bidir_pins_o(pins_o), .bidir_oe_o(oe),
        .input_pins_i(in_pins), .pulldown_off_o(pd_off));
    mgio_board u_mgio_board (.clk_sys_i(clk_sys_i), .out_i(pins_o),
        .oe_i(oe), .ext_i(ext), .ext_drv_i(ext_drv),
        .in_ext_i(in_ext), .in_drv_i(in_drv), .pd_off_i(pd_off),
        .pin_o(pins_i), .in_pin_o(in_pins));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input string nm, input logic [47:0] ex, gt);
        n_checks++;
        if (gt !== ex) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, ex, gt);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [3:0] dv);
        @(posedge clk_sys_i);
        addr  <= a;
        wdat  <= dv;
        wr_en <= 1'b1;
        @(posedge clk_sys_i);
        wr_en <= 1'b0;
        @(negedge clk_sys_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [3:0] ev);
        @(posedge clk_sys_i);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back(ev);
        @(posedge clk_sys_i);
        rd_en <= 1'b0;
        @(negedge clk_sys_i);
    endtask : rd

    // pin levels need the synchroniser depth before reads see them
    task automatic settle();
        repeat (6) @(negedge clk_sys_i);
    endtask : settle

    task automatic close_out();
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    always @(posedge clk_sys_i) begin
        if (rd_seen) begin
            exp_n = exp_q.pop_front();
            chk("rd_data", {44'h0, exp_n}, {44'h0, rd_data});
        end
        rd_seen <= rd_en;
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        chk("oe", 48'h0, oe);
        chk("pins_o", 48'h0, pins_o);
        chk("pd_off", 48'h0, {44'h0, pd_off});
        rd(`MGIO_PULLDOWN_ADDR, 4'h0);
        for (int k = 1; k < 8; k++) begin
            r = xs();
            {e, d, l} = r[11:0];
            wr(`MGIO_PORT_BASE + 8'(k), l);
            chk("latch", {44'h0, l}, {44'h0, pins_o[4*k+:4]});
            chk("oe_in", 48'h0, {44'h0, oe[4*k+:4]});
            wr(`MGIO_DIR_BASE + 8'(k), d);
            ext[4*k+:4] <= e;
            ext_drv[4*k+:4] <= ~d;
            settle();
            chk("oe_bit", {44'h0, d}, {44'h0, oe[4*k+:4]});
            rd(`MGIO_DIR_BASE + 8'(k), d);
            rd(`MGIO_PORT_BASE + 8'(k), (d & l) | (~d & e));
        end
        r = xs();
        {g, e, l} = r[11:0];
        for (int j = 0; j < 4; j++) begin
            wr(`MGIO_PORT_BASE + 8'(8 + j), l);
            ext[32+4*j+:4] <= e;
            ext_drv[32+4*j+:4] <= {4{~g[j]}};
        end
        wr(`MGIO_GROUP_DIR_ADDR, g);
        settle();
        for (int j = 0; j < 4; j++) begin
            chk("oe_grp", {44'h0, {4{g[j]}}}, {44'h0, oe[32+4*j+:4]});
            rd(`MGIO_PORT_BASE + 8'(8 + j), g[j] ? l : e);
        end
        wr(`MGIO_PORT_BASE, 4'hf);
        wr(`MGIO_DIR_BASE, 4'hf);
        ext[3:0] <= 4'b1000;
        ext_drv[3:0] <= 4'b1100;
        settle();
        rd(`MGIO_PORT_BASE, 4'b1011);
        chk("rmw", 48'hb, {44'h0, pins_o[3:0]});
        ext_drv[3:0] <= 4'b0000;
        settle();
        rd(`MGIO_PORT_BASE, 4'b1011);
        r = xs();
        in_ext <= r[11:0];
        in_drv <= 12'hfff;
        for (int i = 0; i < 3; i++)
            wr(`MGIO_IN_PD_ADDR + 8'(i), ~r[4*i+:4]);
        settle();
        for (int i = 0; i < 3; i++)
            rd(`MGIO_IN_PD_ADDR + 8'(i), r[4*i+:4]);
        wr(`MGIO_PULLDOWN_ADDR, 4'h0);
        in_drv <= 12'hff0;
        settle();
        rd(`MGIO_IN_PD_ADDR, 4'h0);
        wr(`MGIO_PULLDOWN_ADDR, 4'ha);
        chk("pd_off", 48'ha, {44'h0, pd_off});
        rd(`MGIO_PULLDOWN_ADDR, 4'ha);
        wr(8'h90, 4'hf);
        rd(8'h90, 4'h0);
        for (int h = 0; h < 3; h++) begin
            @(posedge clk_sys_i);
            {hlt, cs, ce} <= 3'b001 << h;
            o_s = pins_o;
            v_s = oe;
            wr(`MGIO_PORT_BASE + 8'h1, ~pins_o[7:4]);
            wr(`MGIO_DIR_BASE + 8'h1, ~oe[7:4]);
            wr(`MGIO_PULLDOWN_ADDR, 4'h5);
            @(posedge clk_sys_i);
            {hlt, cs, ce} <= 3'b000;
            @(negedge clk_sys_i);
            chk("hold_out", o_s, pins_o);
            chk("hold_oe", v_s, oe);
            chk("hold_pd", 48'ha, {44'h0, pd_off});
        end
        @(posedge clk_sys_i);
        wdr <= 1'b1;
        @(posedge clk_sys_i);
        wdr <= 1'b0;
        @(negedge clk_sys_i);
        chk("wd_oe", 48'h0, oe);
        chk("wd_out", 48'h0, pins_o);
        chk("wd_pd", 48'h0, {44'h0, pd_off});
        repeat (3) @(posedge clk_sys_i);
        close_out();
    end
endmodule : mgio_top_tb
